// ==== core/cte_exec.sv ====
// execution unit for the trap, sign-extend, flag, mask and mac transfer slice
`timescale 1ns/10ps
module cte_exec
	import cte_pkg::*;
#(
	parameter logic [19:0] VEC_ADDR = TRAP_VEC_ADDR
)
(
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	// instruction issue
	input  wire logic        i_start,
	input  wire logic [15:0] i_opcode,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_illegal,
	// memory port
	output logic             o_mem_wr,
	output logic             o_mem_rd,
	output logic      [19:0] o_mem_addr,
	output logic      [15:0] o_mem_wdata,
	input  wire logic [15:0] i_mem_rdata,
	// register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata
);
	import cte_pkg::*;
	generate
		if (VEC_ADDR[0] != 1'b0)
		begin : g_chk
			$error("trap vector address must be word aligned");
		end
	endgenerate
	// =========================================================
	// state
	cte_state_t  state_r;
	logic [3:0]  cnt_r;
	logic [4:0]  cyc_r;
	logic [15:0] op_r;
	logic [15:0] d_r;
	logic [15:0] e_r;
	logic [15:0] ccr_r;
	logic [15:0] pc_r;
	logic [15:0] sp_r;
	logic [3:0]  stk_bank_r;
	logic [3:0]  ext_bank_r;
	logic [3:0]  xk_r;
	logic [3:0]  yk_r;
	logic [3:0]  zk_r;
	logic [7:0]  x_mask_r;
	logic [7:0]  y_mask_r;
	logic [35:0] mac_r;
	logic [35:0] temp;
	logic [15:0] sat;
	logic        ext_ovf;
	logic [15:0] e_nxt;
	logic [19:0] pkpc_nxt;
	logic [19:0] sksp_nxt;
	logic        take;
	logic        ex0;
	logic        ex1;
	logic        last;
	logic        sw_wr;
	function automatic logic [4:0] cyc_of(input logic [15:0] op);
		if (op == OP_TRAP)
			cyc_of = CYC_TRAP;
		else if (op == OP_SEXT || op == OP_MSK || op == OP_LDEB || op == OP_LDSB ||
			op == OP_LDXB || op == OP_LDYB || op == OP_LDZB)
			cyc_of = CYC_2;
		else if (op == OP_WFLG || op == OP_BFLG || op == OP_P2MAC || op == OP_W2MAC)
			cyc_of = CYC_4;
		else if (op == OP_RND)
			cyc_of = CYC_6;
		else
			cyc_of = 5'h00;
	endfunction : cyc_of
	assign take     = i_start && (state_r == CTE_IDLE);
	assign ex0      = (state_r == CTE_RUN) && (cnt_r == 4'h0);
	assign ex1      = (state_r == CTE_RUN) && (cnt_r == 4'h1);
	assign last     = (state_r == CTE_RUN) && ({1'b0, cnt_r} == cyc_r - 5'h01);
	assign sw_wr    = i_wr && (state_r == CTE_IDLE);
	assign pkpc_nxt = {ccr_r[3:0], pc_r} + TWO20;
	assign sksp_nxt = {stk_bank_r, sp_r} - TWO20;
	// saturate only when the mode is on and an overflow is already flagged
	assign e_nxt    = (ccr_r[CC_SAT] && (ccr_r[CC_XOVF] || ccr_r[CC_MOVF])) ?
		sat : temp[31:16];
	cte_mac_round u_round (
		.i_clock   (i_clock),
		.i_rst_b   (i_rst_b),
		.i_capture (ex0 && op_r == OP_RND),
		.i_mac     (mac_r),
		.o_temp    (temp),
		.o_sat     (sat),
		.o_ext_ovf (ext_ovf)
	);
	// =========================================================
	// sequencer
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_r   <= CTE_IDLE;
			cnt_r     <= 4'h0;
			cyc_r     <= 5'h00;
			op_r      <= 16'h0000;
			o_busy    <= 1'b0;
			o_done    <= 1'b0;
			o_illegal <= 1'b0;
		end
		else
		begin
			o_done    <= 1'b0;
			o_illegal <= 1'b0;
			if (take)
			begin
				state_r <= CTE_RUN;
				o_busy  <= 1'b1;
				cnt_r   <= 4'h0;
				op_r    <= i_opcode;
				cyc_r   <= (cyc_of(i_opcode) == 5'h00) ? CYC_ILL : cyc_of(i_opcode);
			end
			else if (last)
			begin
				state_r   <= CTE_IDLE;
				o_busy    <= 1'b0;
				o_done    <= 1'b1;
				o_illegal <= (cyc_of(op_r) == 5'h00);
			end
			else if (state_r == CTE_RUN)
				cnt_r <= cnt_r + 4'h1;
		end
	end
	// =========================================================
	// accumulators
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			d_r <= 16'h0000;
			e_r <= 16'h0000;
		end
		else if (ex0 && op_r == OP_SEXT)
			d_r[15:8] <= d_r[7] ? 8'hFF : 8'h00;
		else if (ex1 && op_r == OP_RND)
			e_r <= e_nxt;
		else if (sw_wr && i_addr == OFS_D)
			d_r <= i_wdata;
		else if (sw_wr && i_addr == OFS_E)
			e_r <= i_wdata;
	end
	// =========================================================
	// flags and program bank
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			ccr_r <= CCR_RST;
		else if (ex0 && op_r == OP_TRAP)
			ccr_r[3:0] <= pkpc_nxt[19:16];
		else if (cnt_r == ST_DEC2 && state_r == CTE_RUN && op_r == OP_TRAP)
			ccr_r[3:0] <= 4'h0;
		else if (ex0 && op_r == OP_SEXT)
		begin
			ccr_r[CC_N] <= d_r[7];
			ccr_r[CC_Z] <= (d_r[7:0] == 8'h00);
		end
		else if (ex0 && op_r == OP_WFLG)
			ccr_r[15:4] <= d_r[15:4];
		else if (ex0 && op_r == OP_BFLG)
			ccr_r[15:8] <= d_r[15:8];
		else if (ex0 && (op_r == OP_P2MAC || op_r == OP_W2MAC))
		begin
			ccr_r[CC_MOVF] <= 1'b0;
			ccr_r[CC_XOVF] <= 1'b0;
		end
		else if (ex1 && op_r == OP_RND)
		begin
			ccr_r[CC_N]  <= e_nxt[15];
			ccr_r[CC_Z]  <= (e_nxt == 16'h0000);
			ccr_r[CC_XOVF] <= ext_ovf;
		end
		else if (sw_wr && i_addr == OFS_CCR)
			ccr_r <= i_wdata;
	end
	// =========================================================
	// program counter and stack
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			pc_r <= 16'h0000;
		else if (ex0 && op_r == OP_TRAP)
			pc_r <= pkpc_nxt[15:0];
		else if (cnt_r == ST_VLD && state_r == CTE_RUN && op_r == OP_TRAP)
			pc_r <= i_mem_rdata;
		else if (sw_wr && i_addr == OFS_PC)
			pc_r <= i_wdata;
	end
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			sp_r       <= 16'h0000;
			stk_bank_r <= 4'h0;
		end
		else if (state_r == CTE_RUN && op_r == OP_TRAP &&
			(cnt_r == ST_DEC1 || cnt_r == ST_DEC2))
			{stk_bank_r, sp_r} <= sksp_nxt;
		else if (ex0 && op_r == OP_LDSB)
			stk_bank_r <= d_r[3:0];
		else if (sw_wr && i_addr == OFS_SP)
			sp_r <= i_wdata;
		else if (sw_wr && i_addr == OFS_STKB)
			stk_bank_r <= i_wdata[3:0];
	end
	// =========================================================
	// banks and masks, no flag effect
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			{ext_bank_r, xk_r, yk_r, zk_r} <= 16'h0000;
		else if (ex0 && op_r == OP_LDEB)
			ext_bank_r <= d_r[3:0];
		else if (ex0 && op_r == OP_LDXB)
			xk_r <= d_r[3:0];
		else if (ex0 && op_r == OP_LDYB)
			yk_r <= d_r[3:0];
		else if (ex0 && op_r == OP_LDZB)
			zk_r <= d_r[3:0];
		else if (sw_wr && i_addr == OFS_BNK)
			{ext_bank_r, xk_r, yk_r, zk_r} <= i_wdata;
	end
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			{x_mask_r, y_mask_r} <= 16'h0000;
		else if ((ex0 && op_r == OP_MSK) || (sw_wr && i_addr == OFS_MSK))
			{x_mask_r, y_mask_r} <= (ex0 && op_r == OP_MSK) ? d_r : i_wdata;
	end
	// =========================================================
	// mac register
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			mac_r <= 36'h000000000;
		else if (ex0 && op_r == OP_P2MAC)
			mac_r <= {{4{e_r[15]}}, e_r, d_r};
		else if (ex0 && op_r == OP_W2MAC)
			mac_r <= {{4{e_r[15]}}, e_r, 16'h0000};
		else if (sw_wr && i_addr == OFS_AML)
			mac_r[15:0] <= i_wdata;
		else if (sw_wr && i_addr == OFS_AMM)
			mac_r[31:16] <= i_wdata;
		else if (sw_wr && i_addr == OFS_AMH)
			mac_r[35:32] <= i_wdata[3:0];
	end
	// =========================================================
	// memory port, pushes go to the current stack slot before it moves
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_mem_wr    <= 1'b0;
			o_mem_rd    <= 1'b0;
			o_mem_addr  <= 20'h00000;
			o_mem_wdata <= 16'h0000;
		end
		else
		begin
			o_mem_wr <= 1'b0;
			o_mem_rd <= 1'b0;
			if (state_r == CTE_RUN && op_r == OP_TRAP && cnt_r == ST_PSHPC)
			begin
				o_mem_wr    <= 1'b1;
				o_mem_addr  <= {stk_bank_r, sp_r};
				o_mem_wdata <= pc_r;
			end
			else if (state_r == CTE_RUN && op_r == OP_TRAP && cnt_r == ST_PSHCC)
			begin
				o_mem_wr    <= 1'b1;
				o_mem_addr  <= {stk_bank_r, sp_r};
				o_mem_wdata <= ccr_r;
			end
			else if (state_r == CTE_RUN && op_r == OP_TRAP && cnt_r == ST_VRD - 4'h1)
			begin
				o_mem_rd   <= 1'b1;
				o_mem_addr <= VEC_ADDR;
			end
		end
	end
	// =========================================================
	// register readback
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_rdata <= 16'h0000;
		else if (!i_rd)
			o_rdata <= 16'h0000;
		else if (i_addr == OFS_D)
			o_rdata <= d_r;
		else if (i_addr == OFS_E)
			o_rdata <= e_r;
		else if (i_addr == OFS_CCR)
			o_rdata <= ccr_r;
		else if (i_addr == OFS_PC)
			o_rdata <= pc_r;
		else if (i_addr == OFS_SP)
			o_rdata <= sp_r;
		else if (i_addr == OFS_STKB)
			o_rdata <= {12'h000, stk_bank_r};
		else if (i_addr == OFS_BNK)
			o_rdata <= {ext_bank_r, xk_r, yk_r, zk_r};
		else if (i_addr == OFS_MSK)
			o_rdata <= {x_mask_r, y_mask_r};
		else if (i_addr == OFS_AML)
			o_rdata <= mac_r[15:0];
		else if (i_addr == OFS_AMM)
			o_rdata <= mac_r[31:16];
		else if (i_addr == OFS_AMH)
			o_rdata <= {12'h000, mac_r[35:32]};
		else if (i_addr == OFS_STAT)
			o_rdata <= {15'h0000, o_busy};
		else
			o_rdata <= 16'h0000;
	end
	// =========================================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	a_trap_pc_adv:   assert property (ex0 && op_r == OP_TRAP |=>
		{ccr_r[3:0], pc_r} == $past({ccr_r[3:0], pc_r}) + TWO20)
		else $error("trap did not advance bank and pc by two");
	a_trap_push_pc:  assert property (ex0 && op_r == OP_TRAP |=> ##1
		o_mem_wr && o_mem_wdata == pc_r)
		else $error("trap did not push pc");
	a_trap_stack:    assert property (ex0 && op_r == OP_TRAP |-> ##5
		{stk_bank_r, sp_r} == $past({stk_bank_r, sp_r}, 5) - 20'h00004)
		else $error("trap stack not lowered by four");
	a_trap_bank_clr: assert property (ex0 && op_r == OP_TRAP |-> ##5 ccr_r[3:0] == 4'h0)
		else $error("trap did not clear program bank");
	a_trap_vector:   assert property (o_mem_rd |=> ##1 pc_r == $past(i_mem_rdata))
		else $error("pc not loaded from vector");
	a_trap_length:   assert property (take && i_opcode == OP_TRAP |-> ##17 o_done)
		else $error("trap length wrong");
	a_sext_value:    assert property (ex0 && op_r == OP_SEXT |=>
		d_r[15:8] == ($past(d_r[7]) ? 8'hFF : 8'h00) && ccr_r[CC_N] == d_r[15])
		else $error("sign extend wrong");
	a_wflg_copy:     assert property (ex0 && op_r == OP_WFLG |=> ccr_r[15:4] == d_r[15:4])
		else $error("word to flags wrong");
	a_mask_load:     assert property (ex0 && op_r == OP_MSK |=>
		{x_mask_r, y_mask_r} == d_r && $stable(ccr_r))
		else $error("mask load wrong");
	a_pair_mac:      assert property (ex0 && op_r == OP_P2MAC |=> mac_r[31:0] == {e_r, d_r}
		&& mac_r[35:32] == {4{mac_r[31]}} && !ccr_r[CC_MOVF] && !ccr_r[CC_XOVF])
		else $error("pair to mac wrong");
	a_rnd_result:    assert property (ex0 && op_r == OP_RND |=> ##1
		e_r == ($past(ccr_r[CC_SAT]) && ($past(ccr_r[CC_XOVF]) || $past(ccr_r[CC_MOVF])) ?
		$past(sat) : $past(temp[31:16])))
		else $error("rounded readback wrong");
	a_word_mac:      assert property (ex0 && op_r == OP_W2MAC |=> mac_r[15:0] == 16'h0000
		&& mac_r[31:16] == e_r)
		else $error("word to mac wrong");
	a_bank_len:      assert property (take && i_opcode == OP_LDXB |-> ##3 o_done)
		else $error("bank transfer length wrong");
	c_trap:  cover property (take && i_opcode == OP_TRAP);
	c_round: cover property (ex1 && op_r == OP_RND && e_nxt == sat);
	c_sext:  cover property (ex0 && op_r == OP_SEXT && d_r[7]);
	c_ill:   cover property (o_illegal);
endmodule : cte_exec

// ==== core/cte_mac_round.sv ====
// rounding and saturation helper for the multiply-accumulate readback
`timescale 1ns/10ps
module cte_mac_round
	import cte_pkg::*;
(
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	// capture request and source
	input  wire logic        i_capture,
	input  wire logic [35:0] i_mac,
	// rounded copy and derived values
	output logic      [35:0] o_temp,
	output logic      [15:0] o_sat,
	output logic             o_ext_ovf
);
	// =========================================================
	// temporary copy
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_temp <= 36'h000000000;
		else if (i_capture)
			o_temp <= i_mac + RND_BIT;
	end
	// extension bits disagree with bit 31 means the upper word cannot hold it
	assign o_ext_ovf = !((&o_temp[35:31]) || !(|o_temp[35:31]));
	assign o_sat     = o_temp[35] ? SAT_NEG : SAT_POS;
endmodule : cte_mac_round

// ==== inc/cte_pkg.sv ====
// shared constants for the transfer and software-trap execution slice
package cte_pkg;
	// =========================================================
	// opcodes
	localparam logic [15:0] OP_TRAP  = 16'h3720;
	localparam logic [15:0] OP_SEXT  = 16'h27F8;
	localparam logic [15:0] OP_WFLG  = 16'h372D;
	localparam logic [15:0] OP_BFLG  = 16'h37FD;
	localparam logic [15:0] OP_MSK   = 16'h372F;
	localparam logic [15:0] OP_P2MAC = 16'h27B1;
	localparam logic [15:0] OP_W2MAC = 16'h27B2;
	localparam logic [15:0] OP_RND   = 16'h27B4;
	localparam logic [15:0] OP_LDEB  = 16'h27FA;
	localparam logic [15:0] OP_LDSB  = 16'h379F;
	localparam logic [15:0] OP_LDXB  = 16'h379C;
	localparam logic [15:0] OP_LDYB  = 16'h379D;
	localparam logic [15:0] OP_LDZB  = 16'h379E;
	// =========================================================
	// cycle counts
	localparam logic [4:0] CYC_TRAP = 5'h10;
	localparam logic [4:0] CYC_2    = 5'h02;
	localparam logic [4:0] CYC_4    = 5'h04;
	localparam logic [4:0] CYC_6    = 5'h06;
	localparam logic [4:0] CYC_ILL  = 5'h01;
	// trap step numbers
	localparam logic [3:0] ST_ADV   = 4'h0;
	localparam logic [3:0] ST_PSHPC = 4'h1;
	localparam logic [3:0] ST_DEC1  = 4'h2;
	localparam logic [3:0] ST_PSHCC = 4'h3;
	localparam logic [3:0] ST_DEC2  = 4'h4;
	localparam logic [3:0] ST_VRD   = 4'h5;
	localparam logic [3:0] ST_VLD   = 4'h6;
	// =========================================================
	// flag-register layout
	localparam int CC_MOVF = 14;
	localparam int CC_XOVF = 12;
	localparam int CC_N    = 11;
	localparam int CC_Z    = 10;
	localparam int CC_SAT  = 4;
	localparam logic [15:0] CCR_RST = 16'h80E0;
	localparam logic [19:0] TRAP_VEC_ADDR = 20'h0000C;
	localparam logic [19:0] TWO20   = 20'h00002;
	localparam logic [35:0] RND_BIT = 36'h000008000;
	localparam logic [15:0] SAT_POS = 16'h7FFF;
	localparam logic [15:0] SAT_NEG = 16'h8000;
	// =========================================================
	// register port offsets
	localparam logic [3:0] OFS_D    = 4'h0;
	localparam logic [3:0] OFS_E    = 4'h1;
	localparam logic [3:0] OFS_CCR  = 4'h2;
	localparam logic [3:0] OFS_PC   = 4'h3;
	localparam logic [3:0] OFS_SP   = 4'h4;
	localparam logic [3:0] OFS_STKB = 4'h5;
	localparam logic [3:0] OFS_BNK  = 4'h6;
	localparam logic [3:0] OFS_MSK  = 4'h7;
	localparam logic [3:0] OFS_AML  = 4'h8;
	localparam logic [3:0] OFS_AMM  = 4'h9;
	localparam logic [3:0] OFS_AMH  = 4'hA;
	localparam logic [3:0] OFS_STAT = 4'hB;
	typedef enum logic {CTE_IDLE, CTE_RUN} cte_state_t;
endpackage : cte_pkg

// ==== tb/cte_exec_tb.sv ====
// self-checking testbench for the transfer and software-trap slice
`timescale 1ns/10ps
module cte_exec_tb;
	import cte_pkg::*;
	localparam logic [19:0] VEC   = 20'h00040;
	localparam logic [15:0] VWORD = 16'h4A5C;
	logic        i_clock  = 1'b0;
	logic        i_rst_b  = 1'b0;
	logic        i_start  = 1'b0;
	logic [15:0] i_opcode = 16'h0000;
	logic [3:0]  i_addr   = 4'h0;
	logic [15:0] i_wdata  = 16'h0000;
	logic        i_wr     = 1'b0;
	logic        i_rd     = 1'b0;
	logic        o_busy, o_done, o_illegal, o_mem_wr, o_mem_rd;
	logic [19:0] o_mem_addr;
	logic [15:0] o_mem_wdata, i_mem_rdata, o_rdata, rv;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	logic [15:0] bank_op [5] = '{OP_LDEB, OP_LDSB, OP_LDXB, OP_LDYB, OP_LDZB};
	logic [15:0] rnd_ccr [5] = '{16'h0000, 16'h1010, 16'h4010, 16'h1000, 16'h0010};
	logic [15:0] rnd_e   [5] = '{16'h8000, 16'h7FFF, 16'h7FFF, 16'h8000, 16'h8000};

	always #50 i_clock = ~i_clock;

	cte_exec #(.VEC_ADDR(VEC)) cte_exec_i (
		.i_clock(i_clock), .i_rst_b(i_rst_b), .i_start(i_start), .i_opcode(i_opcode),
		.o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal), .o_mem_wr(o_mem_wr),
		.o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
		.i_mem_rdata(i_mem_rdata), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata));

	cte_mem_model #(.VEC_ADDR(VEC), .VEC_WORD(VWORD)) cte_mem_model_i (
		.i_clock(i_clock), .i_mem_wr(o_mem_wr), .i_mem_rd(o_mem_rd),
		.i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata));

	// =========================================================
	// shared tasks
	task automatic stop_test();
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge i_clock);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		@(negedge i_clock);
		rv = o_rdata;
	endtask : rd

	task automatic rc(input logic [3:0] a, input logic [15:0] e, input string nm);
		rd(a);
		chk(nm, {4'h0, rv}, {4'h0, e});
	endtask : rc

	// done must land n cycles after the take edge, seen at the (n+1)th falling edge
	task automatic run(input logic [15:0] op, input int n, input logic ill);
		int k;
		@(posedge i_clock);
		i_start  <= 1'b1;
		i_opcode <= op;
		@(posedge i_clock);
		i_start <= 1'b0;
		k = 0;
		do
		begin
			@(negedge i_clock);
			k++;
			if (k == 1)
				chk("busy after take", {19'h0, o_busy}, 20'h00001);
		end
		while (o_done !== 1'b1 && k < 40);
		chk("done cycle", 20'(k), 20'(n + 1));
		chk("busy at done", {19'h0, o_busy}, 20'h00000);
		chk("illegal flag", {19'h0, o_illegal}, {19'h0, ill});
	endtask : run

	// =========================================================
	// hang guard: whole sequence needs well under 2000 cycles
	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			stop_test();
		end
	end

	// =========================================================
	// main sequence
	initial
	begin
		repeat (2) @(posedge i_clock);
		i_rst_b <= 1'b1;
		for (int a = 0; a < 12; a++)
			rc(4'(a), (a == 2) ? CCR_RST : 16'h0000, "reset value");
		@(negedge i_clock);
		chk("read data after slot", {4'h0, o_rdata}, 20'h00000);
		rc(4'hC, 16'h0000, "unmapped read");
		// trap with pc carry into bank and stack borrow out of bank
		wr(OFS_PC, 16'hFFFE);
		wr(OFS_SP, 16'h0000);
		wr(OFS_STKB, 16'h0005);
		wr(OFS_CCR, 16'h8003);
		run(OP_TRAP, 16, 1'b0);
		chk("push count", 20'(cte_mem_model_i.wr_addr_q.size()), 20'h00002);
		chk("pc push addr", cte_mem_model_i.wr_addr_q[0], 20'h50000);
		chk("pc push data", {4'h0, cte_mem_model_i.wr_data_q[0]}, 20'h00000);
		chk("flag push addr", cte_mem_model_i.wr_addr_q[1], 20'h4FFFE);
		chk("flag push data", {4'h0, cte_mem_model_i.wr_data_q[1]}, 20'h08004);
		rc(OFS_SP, 16'hFFFC, "stack pointer");
		rc(OFS_STKB, 16'h0004, "stack bank");
		rc(OFS_CCR, 16'h8000, "flags after trap");
		rc(OFS_PC, VWORD, "pc from vector");
		// sign extend, negative then zero
		wr(OFS_D, 16'h1280);
		run(OP_SEXT, 2, 1'b0);
		rc(OFS_D, 16'hFF80, "sign extend neg");
		rd(OFS_CCR);
		chk("n z neg", {18'h0, rv[CC_N], rv[CC_Z]}, 20'h00002);
		wr(OFS_D, 16'h7F00);
		run(OP_SEXT, 2, 1'b0);
		rc(OFS_D, 16'h0000, "sign extend pos");
		rd(OFS_CCR);
		chk("n z zero", {18'h0, rv[CC_N], rv[CC_Z]}, 20'h00001);
		// flag transfers
		wr(OFS_D, 16'hA5F7);
		run(OP_WFLG, 4, 1'b0);
		rc(OFS_CCR, 16'hA5F0, "word to flags");
		wr(OFS_D, 16'h3C00);
		run(OP_BFLG, 4, 1'b0);
		rc(OFS_CCR, 16'h3CF0, "byte to flags");
		// mask load keeps flags
		wr(OFS_D, 16'h9A35);
		run(OP_MSK, 2, 1'b0);
		rc(OFS_MSK, 16'h9A35, "index masks");
		rc(OFS_CCR, 16'h3CF0, "flags after mask");
		// mac loads with both overflows set beforehand
		wr(OFS_CCR, 16'h5000);
		wr(OFS_E, 16'h8001);
		wr(OFS_D, 16'h1234);
		run(OP_P2MAC, 4, 1'b0);
		rc(OFS_AML, 16'h1234, "mac low");
		rc(OFS_AMM, 16'h8001, "mac mid");
		rc(OFS_AMH, 16'h000F, "mac top");
		rc(OFS_CCR, 16'h0000, "overflows cleared");
		wr(OFS_CCR, 16'h5000);
		wr(OFS_E, 16'h7FFF);
		run(OP_W2MAC, 4, 1'b0);
		rc(OFS_AML, 16'h0000, "mac low word");
		rc(OFS_AMM, 16'h7FFF, "mac mid word");
		rc(OFS_AMH, 16'h0000, "mac top word");
		rc(OFS_CCR, 16'h0000, "overflows cleared word");
		// rounded readback: 0_7FFF_8000 rounds to 0_8000_0000
		wr(OFS_D, 16'h8000);
		run(OP_P2MAC, 4, 1'b0);
		for (int i = 0; i < 5; i++)
		begin
			wr(OFS_CCR, rnd_ccr[i]);
			run(OP_RND, 6, 1'b0);
			rc(OFS_E, rnd_e[i], "rounded readback");
		end
		rd(OFS_CCR);
		chk("overflow n z", {17'h0, rv[CC_XOVF], rv[CC_N], rv[CC_Z]}, 20'h00006);
		// bank transfers use only the low nibble of b
		wr(OFS_CCR, 16'h8C05);
		for (int i = 0; i < 5; i++)
		begin
			wr(OFS_D, 16'h00A1 + 16'(i));
			run(bank_op[i], 2, 1'b0);
		end
		rc(OFS_BNK, 16'h1345, "bank registers");
		rc(OFS_STKB, 16'h0002, "stack bank load");
		rc(OFS_CCR, 16'h8C05, "flags after banks");
		run(16'h0000, 1, 1'b1);
		rc(OFS_CCR, 16'h8C05, "flags after illegal");
		stop_test();
	end
endmodule : cte_exec_tb

// ==== tb/cte_mem_model.sv ====
// far-side memory model: takes stack pushes, answers trap vector reads
`timescale 1ns/10ps
module cte_mem_model
#(
	parameter logic [19:0] VEC_ADDR = 20'h0000C,
	parameter logic [15:0] VEC_WORD = 16'h4A5C
)
(
	// clock
	input  wire logic        i_clock,
	// memory port
	input  wire logic        i_mem_wr,
	input  wire logic        i_mem_rd,
	input  wire logic [19:0] i_mem_addr,
	input  wire logic [15:0] i_mem_wdata,
	output logic      [15:0] o_mem_rdata
);
	logic [19:0] wr_addr_q [$];
	logic [15:0] wr_data_q [$];
	initial o_mem_rdata = 16'h5A5A;
	// =========================================================
	// read data valid only in the cycle after the strobe; toggles otherwise
	// so a sample one cycle late sees the inverted word, not the good one
	always @(posedge i_clock)
	begin
		if (i_mem_rd)
			o_mem_rdata <= (i_mem_addr == VEC_ADDR) ? VEC_WORD : 16'hDEAD;
		else
			o_mem_rdata <= ~o_mem_rdata;
		if (i_mem_wr)
		begin
			wr_addr_q.push_back(i_mem_addr);
			wr_data_q.push_back(i_mem_wdata);
		end
	end
endmodule : cte_mem_model
